/* File: src/mid_pkg.sv */
// Constants and types for the upper instruction decoder.
// Assumes a 16-bit instruction word from program ROM.
package mid_pkg;

  // ----------------------------------------
  // Opcode patterns: {value, fixed-bit mask}
  // ----------------------------------------
  localparam logic [31:0] OPC_MWR_IND = 32'h6f00_ff80;
  localparam logic [31:0] OPC_MV_WREG = 32'h7000_f800;
  localparam logic [31:0] OPC_MV_RAM  = 32'h7800_f800;
  localparam logic [31:0] OPC_JBIT    = 32'h8000_e000;
  localparam logic [31:0] OPC_JNZ     = 32'ha000_f800;
  localparam logic [31:0] OPC_JNC     = 32'ha800_f800;
  localparam logic [31:0] OPC_JZ      = 32'hb000_f800;
  localparam logic [31:0] OPC_JC      = 32'hb800_f800;
  localparam logic [31:0] OPC_CALL    = 32'hc000_f800;
  localparam logic [31:0] OPC_JMP     = 32'hd000_f800;
  localparam logic [31:0] OPC_RTS     = 32'hd800_ffff;
  localparam logic [31:0] OPC_SCC     = 32'hd900_ffb8;
  localparam logic [31:0] OPC_SPA     = 32'hdc00_ffe0;
  localparam logic [31:0] OPC_SPB     = 32'hdd00_ffe0;
  localparam logic [31:0] OPC_SPC     = 32'hde00_ffe0;
  localparam logic [31:0] OPC_TIMER1_IMMEDIATE_LOAD    = 32'he200_ff00;
  localparam logic [31:0] OPC_SPK     = 32'he300_ff80;
  localparam logic [31:0] OPC_TIMER2_IMMEDIATE_LOAD    = 32'he600_fe00;
  localparam logic [31:0] OPC_SHE     = 32'he800_ff81;
  localparam logic [31:0] OPC_SIE     = 32'he900_ff80;
  localparam logic [31:0] OPC_PLC     = 32'hea00_fe80;
  localparam logic [31:0] OPC_SRE     = 32'hed00_ff4f;
  localparam logic [31:0] OPC_FAST    = 32'hee00_ffff;
  localparam logic [31:0] OPC_SLOW    = 32'hef00_ffff;
  localparam logic [31:0] OPC_SF      = 32'hf000_ff60;
  localparam logic [31:0] OPC_RF      = 32'hf400_ff68;
  localparam logic [31:0] OPC_SF2     = 32'hf800_fff0;
  localparam logic [31:0] OPC_RF2     = 32'hf900_fff0;
  localparam logic [31:0] OPC_ALM     = 32'hfa00_fe00;
  localparam logic [31:0] OPC_ELC     = 32'hfc00_fe00;
  localparam logic [31:0] OPC_HALT    = 32'hfe00_ffff;
  localparam logic [31:0] OPC_STOP    = 32'hff00_ffff;

  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam int         WREG_DEPTH = 16;
  localparam logic [3:0] ACC_RST    = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b100
  } mid_state_t;

  // Peripheral configuration written by control opcodes
  typedef struct packed {
    logic        tone_clk_instr; // 1: instruction clock, 0: stage 0
    logic [2:0]  debounce_sel;   // 001 stage 10, 010 stage 8
    logic [2:0]  port_pull;      // C,B,A pull-low (C also low hold)
    logic [11:0] port_dir;       // C[11:8] B[7:4] A[3:0]
    logic [1:0]  t1_clk;
    logic [5:0]  t1_preset;
    logic [2:0]  t2_clk;
    logic [5:0]  t2_preset;
    logic        key_rel_scan;
    logic        key_hiz;
    logic        key_all_high;
    logic [3:0]  key_line;
    logic [6:1]  halt_wake_enable;
    logic [6:0]  irq_enable;
    logic [2:0]  stop_wake_enable; // port C, ext int, key scan
    logic [2:0]  buzz_src;
    logic [5:0]  buzz_mod;
    logic        el_pump_div_clk;
    logic [1:0]  el_pump_div;
    logic [1:0]  el_pump_duty;
    logic [1:0]  el_drive_clk;
    logic [1:0]  el_drive_duty;
  } mid_cfg_t;

  // System flags
  typedef struct packed {
    logic timer_reload_one;
    logic watchdog_enable_flag;
    logic halt_after_el;
    logic el_light;
    logic backup_flag;
    logic carry_flag;
    logic irq_pin_strong_pulldown;
    logic segments_blank;
    logic counter_enable_override;
    logic timer_reload_two;
    logic sclk_fast;
  } mid_flags_t;

endpackage

/* File: src/mid_wreg_file.sv */
// Working register file, one nibble per entry.
// Assumes a single clock; read is combinational.
`timescale 1ns/1ps
`default_nettype none
module mid_wreg_file #(
  parameter int DEPTH = 16,
  parameter int W     = 4
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  // Write port
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [W-1:0]             wdata_i,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [W-1:0]             rdata_o
);
  logic [W-1:0] mem_q [DEPTH];

  // Storage, cleared at reset
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Read selection
  assign rdata_o = mem_q[raddr_i];
endmodule
`default_nettype wire

/* File: src/mid_decoder.sv */
// Upper instruction decoder and executor: moves, jumps, calls, control ops.
// Assumes the instruction at pc_o is offered with instr_valid_i, RAM read
// data follows ram_raddr_o in the same cycle, and wake events are pulses.
// ----------------------------------------
// Behaviour
// - Indirect move copies RAM at index pointer into accumulator and addressed RAM
// - Prefix 0111 moves nibble RAM to working reg or back; accumulator also loaded
// - Bit-test jumps pick accumulator bit by bits 12:11, jump when it is one
// - Nonzero-test and zero-test jumps follow the accumulator value
// - Carry-clear and carry-set jumps follow the carry flag
// - Call pushes program counter plus one, then jumps to target
// - Jump loads target; return restores the counter pushed by call
// - Port setup ops set pull-low from bit 4 and directions from 3..0
// - Timer-1 immediate loads preset 5..0 and clock choice 7:6
// - Timer-2 immediate loads preset 5..0 and clock choice 8..6
// - Key-scan setup sets release mode, high-z, all-high and line select
// - Halt-wake enable op writes six enables from bits 6..1
// - Interrupt enable op writes seven enables from bits 6..0
// - Two fixed opcodes select fast or slow instruction clock
// - Flag-set op sets reload 1, watchdog, halt-after-EL, EL light, backup, carry
// - Flag-reset op clears reload 1, watchdog, EL light, backup, carry
// - Second set/reset ops drive pull-down, blanking, override, reload 2
// - Buzzer op selects source from 8..6 and modulation gates from 5..0
// - EL-panel op sets pump clock, pump duty, drive clock and drive duty
// - Halt and stop opcodes suspend execution until an enabled wake source
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module mid_decoder
  import mid_pkg::*;
#(
  parameter int PC_W        = 11,
  parameter int STACK_DEPTH = 4,
  parameter int RAM_AW      = 7
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  // Instruction stream
  input  wire logic [15:0]       instr_i,
  input  wire logic              instr_valid_i,
  output logic      [PC_W-1:0]   pc_o,
  // Data RAM
  input  wire logic [RAM_AW-1:0] index_pointer_i,
  output logic      [RAM_AW-1:0] ram_raddr_o,
  input  wire logic [3:0]        ram_rdata_i,
  output logic                   ram_we_o,
  output logic      [RAM_AW-1:0] ram_waddr_o,
  output logic      [3:0]        ram_wdata_o,
  // Wake sources
  input  wire logic [6:0]        wake_evt_i,
  input  wire logic [2:0]        stop_evt_i,
  // State and configuration
  output logic      [3:0]        acc_o,
  output mid_pkg::mid_cfg_t      cfg_o,
  output mid_pkg::mid_flags_t    flags_o,
  output logic      [6:0]        halt_wake_request_o,
  output logic                   halted_o,
  output logic                   stopped_o,
  // Side-effect pulses
  output logic                   timer1_load_o,
  output logic                   timer2_load_o,
  output logic                   prediv_reset_o,
  output logic                   wdt_clear_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic hit(input logic [15:0] w, input logic [31:0] p);
    hit = (w & p[15:0]) == p[31:16];
  endfunction

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam int WA_W = $clog2(WREG_DEPTH);

  mid_state_t        state_q, state_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic [PC_W-1:0]   stk_q [STACK_DEPTH];
  logic [SP_W-1:0]   sp_q;
  logic [3:0]        acc_q, acc_d;
  mid_cfg_t          cfg_q, cfg_d;
  mid_flags_t        flg_q, flg_d;
  logic [6:0]        hreq_q, hreq_clr;
  logic              ram_we_q;
  logic [RAM_AW-1:0] ram_waddr_q;
  logic [3:0]        ram_wdata_q;
  logic              t1_ld_q, t2_ld_q, pdr_q, wdc_q;
  logic [3:0]        wreg_rdata;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Execution happens only in run state with a valid word
  wire exec   = instr_valid_i && (state_q == ST_RUN);
  wire d_mwri = hit(instr_i, OPC_MWR_IND);
  wire d_mvw  = hit(instr_i, OPC_MV_WREG);
  wire d_mvr  = hit(instr_i, OPC_MV_RAM);
  wire d_jbit = hit(instr_i, OPC_JBIT);
  wire d_jnz  = hit(instr_i, OPC_JNZ);
  wire d_jnc  = hit(instr_i, OPC_JNC);
  wire d_jz   = hit(instr_i, OPC_JZ);
  wire d_jc   = hit(instr_i, OPC_JC);
  wire d_call = hit(instr_i, OPC_CALL);
  wire d_jmp  = hit(instr_i, OPC_JMP);
  wire d_rts  = hit(instr_i, OPC_RTS);
  wire d_halt = hit(instr_i, OPC_HALT);
  wire d_stop = hit(instr_i, OPC_STOP);
  wire d_sf   = hit(instr_i, OPC_SF);
  wire d_fast = hit(instr_i, OPC_FAST);

  // Operand fields
  wire [PC_W-1:0]   tgt     = instr_i[PC_W-1:0];
  wire [PC_W-1:0]   pc_inc  = pc_q + 1'b1;
  wire [RAM_AW-1:0] ram_x   = instr_i[RAM_AW-1:0];
  wire [WA_W-1:0]   wreg_y  = instr_i[10:7];
  wire              acc_bit = acc_q[instr_i[12:11]];

  // Jump decision
  wire jump = (d_jbit && acc_bit)
           || (d_jnz && (acc_q != 4'h0))
           || (d_jz && (acc_q == 4'h0))
           || (d_jnc && !flg_q.carry_flag)
           || (d_jc && flg_q.carry_flag)
           || d_call || d_jmp;

  // RAM read address: index pointer for indirect move
  assign ram_raddr_o = d_mwri ? index_pointer_i : ram_x;

  // Wake conditions
  wire halt_wake = |(hreq_q[6:1] & cfg_q.halt_wake_enable);
  wire stop_wake = |(stop_evt_i & cfg_q.stop_wake_enable);

  // ----------------------------------------
  // Program counter, state and stack
  // ----------------------------------------
  // Next counter: target, pop, or increment
  always_comb begin
    pc_d = pc_q;
    if (exec) begin
      if (jump) begin
        pc_d = tgt;
      end else if (d_rts) begin
        pc_d = stk_q[sp_q - 1'b1];
      end else begin
        pc_d = pc_inc;
      end
    end
  end

  // Run, halt and stop sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (exec && d_halt) begin
          state_d = ST_HALT;
        end else if (exec && d_stop) begin
          state_d = ST_STOP;
        end
      end
      ST_HALT: begin
        if (halt_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (stop_wake) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // Counter and state registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_q    <= '0;
      state_q <= ST_RUN;
    end else begin
      pc_q    <= pc_d;
      state_q <= state_d;
    end
  end

  // Return stack, wraps when over-used
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_q[i] <= '0;
      end
    end else if (exec && d_call) begin
      stk_q[sp_q] <= pc_inc;
      sp_q        <= sp_q + 1'b1;
    end else if (exec && d_rts) begin
      sp_q <= sp_q - 1'b1;
    end
  end

  // ----------------------------------------
  // Data moves
  // ----------------------------------------
  // Working register file
  mid_wreg_file #(
    .DEPTH (WREG_DEPTH),
    .W     (4)
  ) u_wreg (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (exec && d_mvw),
    .waddr_i   (wreg_y),
    .wdata_i   (ram_rdata_i),
    .raddr_i   (wreg_y),
    .rdata_o   (wreg_rdata)
  );

  // Accumulator follows every move
  always_comb begin
    acc_d = acc_q;
    if (exec && (d_mwri || d_mvw)) begin
      acc_d = ram_rdata_i;
    end else if (exec && d_mvr) begin
      acc_d = wreg_rdata;
    end
  end

  // Registered RAM write port
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_q       <= ACC_RST;
      ram_we_q    <= 1'b0;
      ram_waddr_q <= '0;
      ram_wdata_q <= 4'h0;
    end else begin
      acc_q       <= acc_d;
      ram_we_q    <= exec && (d_mwri || d_mvr);
      ram_waddr_q <= ram_x;
      ram_wdata_q <= d_mvr ? wreg_rdata : ram_rdata_i;
    end
  end

  // ----------------------------------------
  // Control opcodes
  // ----------------------------------------
  // Configuration and flag updates
  always_comb begin
    cfg_d    = cfg_q;
    flg_d    = flg_q;
    hreq_clr = 7'h00;
    if (exec) begin
      if (hit(instr_i, OPC_SCC)) begin
        cfg_d.tone_clk_instr = instr_i[6];
        cfg_d.debounce_sel   = instr_i[2:0];
      end
      if (hit(instr_i, OPC_SPA)) begin
        cfg_d.port_pull[0]  = instr_i[4];
        cfg_d.port_dir[3:0] = instr_i[3:0];
      end
      if (hit(instr_i, OPC_SPB)) begin
        cfg_d.port_pull[1]  = instr_i[4];
        cfg_d.port_dir[7:4] = instr_i[3:0];
      end
      if (hit(instr_i, OPC_SPC)) begin
        cfg_d.port_pull[2]   = instr_i[4];
        cfg_d.port_dir[11:8] = instr_i[3:0];
      end
      if (hit(instr_i, OPC_TIMER1_IMMEDIATE_LOAD)) begin
        cfg_d.t1_clk    = instr_i[7:6];
        cfg_d.t1_preset = instr_i[5:0];
      end
      if (hit(instr_i, OPC_TIMER2_IMMEDIATE_LOAD)) begin
        cfg_d.t2_clk    = instr_i[8:6];
        cfg_d.t2_preset = instr_i[5:0];
      end
      if (hit(instr_i, OPC_SPK)) begin
        cfg_d.key_rel_scan = instr_i[6];
        cfg_d.key_hiz      = instr_i[5];
        cfg_d.key_all_high = instr_i[4];
        cfg_d.key_line     = instr_i[3:0];
      end
      if (hit(instr_i, OPC_SHE)) begin
        cfg_d.halt_wake_enable = instr_i[6:1];
      end
      if (hit(instr_i, OPC_SIE)) begin
        cfg_d.irq_enable = instr_i[6:0];
      end
      if (hit(instr_i, OPC_PLC)) begin
        hreq_clr = instr_i[6:0];
      end
      if (hit(instr_i, OPC_SRE)) begin
        cfg_d.stop_wake_enable = {instr_i[4], instr_i[5], instr_i[7]};
      end
      if (d_fast) begin
        flg_d.sclk_fast = 1'b1;
      end
      if (hit(instr_i, OPC_SLOW)) begin
        flg_d.sclk_fast = 1'b0;
      end
      if (d_sf) begin
        flg_d.timer_reload_one     |= instr_i[7];
        flg_d.watchdog_enable_flag |= instr_i[4];
        flg_d.halt_after_el        |= instr_i[3];
        flg_d.el_light             |= instr_i[2];
        flg_d.backup_flag          |= instr_i[1];
        flg_d.carry_flag           |= instr_i[0];
      end
      if (hit(instr_i, OPC_RF)) begin
        flg_d.timer_reload_one     &= !instr_i[7];
        flg_d.watchdog_enable_flag &= !instr_i[4];
        flg_d.el_light             &= !instr_i[2];
        flg_d.backup_flag          &= !instr_i[1];
        flg_d.carry_flag           &= !instr_i[0];
      end
      if (hit(instr_i, OPC_SF2)) begin
        flg_d.irq_pin_strong_pulldown |= instr_i[3];
        flg_d.segments_blank          |= instr_i[2];
        flg_d.counter_enable_override |= instr_i[1];
        flg_d.timer_reload_two        |= instr_i[0];
      end
      if (hit(instr_i, OPC_RF2)) begin
        flg_d.irq_pin_strong_pulldown &= !instr_i[3];
        flg_d.segments_blank          &= !instr_i[2];
        flg_d.counter_enable_override &= !instr_i[1];
        flg_d.timer_reload_two        &= !instr_i[0];
      end
      if (hit(instr_i, OPC_ALM)) begin
        cfg_d.buzz_src = instr_i[8:6];
        cfg_d.buzz_mod = instr_i[5:0];
      end
      if (hit(instr_i, OPC_ELC)) begin
        cfg_d.el_pump_div_clk = instr_i[8];
        cfg_d.el_pump_div     = instr_i[7:6];
        cfg_d.el_pump_duty    = instr_i[5:4];
        cfg_d.el_drive_clk    = instr_i[3:2];
        cfg_d.el_drive_duty   = instr_i[1:0];
      end
    end
  end

  // Configuration, flags and sticky wake requests; new event beats clear
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_q  <= '0;
      flg_q  <= '0;
      hreq_q <= 7'h00;
    end else begin
      cfg_q  <= cfg_d;
      flg_q  <= flg_d;
      hreq_q <= (hreq_q & ~hreq_clr) | wake_evt_i;
    end
  end

  // Side-effect pulses, one cycle each
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      t1_ld_q <= 1'b0;
      t2_ld_q <= 1'b0;
      pdr_q   <= 1'b0;
      wdc_q   <= 1'b0;
    end else begin
      t1_ld_q <= exec && hit(instr_i, OPC_TIMER1_IMMEDIATE_LOAD);
      t2_ld_q <= exec && hit(instr_i, OPC_TIMER2_IMMEDIATE_LOAD);
      pdr_q   <= exec && hit(instr_i, OPC_PLC) && instr_i[8];
      wdc_q   <= exec && hit(instr_i, OPC_RF) && instr_i[4];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pc_o                = pc_q;
  assign acc_o               = acc_q;
  assign cfg_o               = cfg_q;
  assign flags_o             = flg_q;
  assign halt_wake_request_o = hreq_q;
  assign halted_o            = state_q == ST_HALT;
  assign stopped_o           = state_q == ST_STOP;
  assign ram_we_o            = ram_we_q;
  assign ram_waddr_o         = ram_waddr_q;
  assign ram_wdata_o         = ram_wdata_q;
  assign timer1_load_o       = t1_ld_q;
  assign timer2_load_o       = t2_ld_q;
  assign prediv_reset_o      = pdr_q;
  assign wdt_clear_o         = wdc_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  wire [PC_W-1:0] stk_top = stk_q[sp_q - 1'b1];

  property p_mwr_ind;
    exec && d_mwri |=> ram_we_o && acc_o == $past(ram_rdata_i)
      && ram_wdata_o == $past(ram_rdata_i) && ram_waddr_o == $past(ram_x);
  endproperty
  a_mwr_ind: assert property (p_mwr_ind) else $error("indirect move wrong");

  property p_mv_ram;
    exec && d_mvr |=> ram_we_o && ram_wdata_o == $past(wreg_rdata) && acc_o == ram_wdata_o;
  endproperty
  a_mv_ram: assert property (p_mv_ram) else $error("move to RAM wrong");

  property p_jbit;
    exec && d_jbit && !acc_bit |=> pc_o == $past(pc_inc);
  endproperty
  a_jbit: assert property (p_jbit) else $error("bit jump taken wrongly");

  property p_jz;
    exec && d_jz && acc_o == 4'h0 |=> pc_o == $past(tgt);
  endproperty
  a_jz: assert property (p_jz) else $error("zero jump missed");

  property p_jc;
    exec && d_jc && !flags_o.carry_flag |=> pc_o == $past(pc_inc);
  endproperty
  a_jc: assert property (p_jc) else $error("carry jump wrong");

  property p_call;
    exec && d_call |=> stk_top == $past(pc_inc) && pc_o == $past(tgt);
  endproperty
  a_call: assert property (p_call) else $error("call push wrong");

  property p_halt;
    exec && d_halt && !halt_wake |=> halted_o ##1 (halted_o || $past(halt_wake));
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered");

  property p_fast;
    exec && d_fast |=> flags_o.sclk_fast;
  endproperty
  a_fast: assert property (p_fast) else $error("fast clock not set");

  property p_sf;
    exec && d_sf && instr_i[0] |=> flags_o.carry_flag;
  endproperty
  a_sf: assert property (p_sf) else $error("carry not set");

endmodule
`default_nettype wire

/* File: test/mid_rom_model.sv */
// Program ROM model for the upper decoder bench.
// Assumes the bench loads words hierarchically; unwritten words read as zero.
`timescale 1ns/1ps
`default_nettype none
module mid_rom_model (
  // Fetch port
  input  wire logic [10:0] addr_i,
  output logic      [15:0] data_o
);
  logic [15:0] mem [0:2047];

  // Blank ROM holds no-operation words
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end

  // Combinational fetch at the program counter
  assign data_o = mem[addr_i];
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the upper instruction decoder.
// Assumes the ROM model answers combinationally at pc_o.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb;
  import mid_pkg::*;
  typedef struct packed {
    logic [15:0] w; logic [3:0] rd; logic [10:0] pc; logic [3:0] acc; logic we;
  } mid_row_t;
  logic mclk_i = 0, sys_rst_i = 1, instr_valid_i = 0, ram_we_o, halted_o, stopped_o;
  logic t1_o, t2_o, pd_o, wd_o;
  logic [2:0] stop_evt_i = 0;
  logic [15:0] instr_i;
  logic [10:0] pc_o, p;
  logic [3:0] ram_rdata_i = 0, acc_o, ram_wdata_o;
  logic [6:0] wake_evt_i = 0, ram_raddr_o, ram_waddr_o, halt_wake_request_o;
  mid_cfg_t cfg_o;
  mid_flags_t flags_o;
  int err_count = 0, check_count = 0;
  // Word, RAM data, then expected pc, accumulator and RAM write strobe
  mid_row_t rows [20] = '{
    '{16'h6f01,4'h5,11'h001,4'h5,1'b1}, '{16'h8010,4'h5,11'h010,4'h5,1'b0},
    '{16'h8820,4'h5,11'h011,4'h5,1'b0}, '{16'ha040,4'h5,11'h040,4'h5,1'b0},
    '{16'hb050,4'h5,11'h041,4'h5,1'b0}, '{16'ha860,4'h5,11'h060,4'h5,1'b0},
    '{16'hb870,4'h5,11'h061,4'h5,1'b0}, '{16'hc123,4'h5,11'h123,4'h5,1'b0},
    '{16'hd800,4'h5,11'h062,4'h5,1'b0}, '{16'hd200,4'h5,11'h200,4'h5,1'b0},
    '{16'h7085,4'h9,11'h201,4'h9,1'b0}, '{16'h7885,4'h9,11'h202,4'h9,1'b1},
    '{16'hf001,4'h9,11'h203,4'h9,1'b0}, '{16'hb900,4'h9,11'h100,4'h9,1'b0},
    '{16'h0000,4'h9,11'h101,4'h9,1'b0}, '{16'h9a00,4'h9,11'h200,4'h9,1'b0},
    '{16'h6f02,4'h0,11'h201,4'h0,1'b1}, '{16'hb300,4'h0,11'h300,4'h0,1'b0},
    '{16'ha350,4'h0,11'h301,4'h0,1'b0}, '{16'ha870,4'h0,11'h302,4'h0,1'b0}};

  // Free-running clock
  always #5 mclk_i = ~mclk_i;

  mid_rom_model i_rom (.addr_i(pc_o), .data_o(instr_i));

  mid_decoder i_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .pc_o(pc_o), .index_pointer_i(7'h0a),
    .ram_raddr_o(ram_raddr_o), .ram_rdata_i(ram_rdata_i), .ram_we_o(ram_we_o),
    .ram_waddr_o(ram_waddr_o), .ram_wdata_o(ram_wdata_o), .wake_evt_i(wake_evt_i),
    .stop_evt_i(stop_evt_i), .acc_o(acc_o), .cfg_o(cfg_o), .flags_o(flags_o),
    .halt_wake_request_o(halt_wake_request_o), .halted_o(halted_o),
    .stopped_o(stopped_o), .timer1_load_o(t1_o), .timer2_load_o(t2_o),
    .prediv_reset_o(pd_o), .wdt_clear_o(wd_o));

  // Verdict and end of run
  task automatic tally_and_finish();
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Place a word at the current pc and let one edge take it
  task automatic exec(input logic [15:0] w);
    i_rom.mem[pc_o] = w;
    @(posedge mclk_i);
    #1;
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    sys_rst_i = 0;
    `CHK(pc_o, 11'h000);
    instr_valid_i = 1;
    foreach (rows[i]) begin
      ram_rdata_i = rows[i].rd;
      exec(rows[i].w);
      `CHK(pc_o, rows[i].pc);
      `CHK(acc_o, rows[i].acc);
      `CHK(ram_we_o, rows[i].we);
      if (rows[i].we) `CHK(ram_wdata_o, rows[i].acc);
    end
    i_rom.mem[pc_o] = 16'h6f05;
    #1;
    `CHK(ram_raddr_o, 7'h0a);
    exec(16'h6f05);
    `CHK(ram_waddr_o, 7'h05);
    exec(16'hd941);
    `CHK({cfg_o.tone_clk_instr, cfg_o.debounce_sel}, 4'h9);
    exec(16'he2c5);
    `CHK({t1_o, cfg_o.t1_clk, cfg_o.t1_preset}, 9'h1c5);
    exec(16'hf410);
    `CHK({wd_o, flags_o.watchdog_enable_flag}, 2'b10);
    exec(16'hee00);
    `CHK(flags_o.sclk_fast, 1'b1);
    exec(16'hf804);
    `CHK(flags_o.segments_blank, 1'b1);
    exec(16'hdc1a);
    exec(16'hdd05);
    exec(16'hde13);
    `CHK({cfg_o.port_pull, cfg_o.port_dir}, 15'h535a);
    exec(16'he7c9);
    `CHK({t2_o, cfg_o.t2_clk, cfg_o.t2_preset}, 10'h3c9);
    exec(16'he35b);
    `CHK({cfg_o.key_rel_scan, cfg_o.key_hiz, cfg_o.key_all_high}, 3'h5);
    `CHK(cfg_o.key_line, 4'hb);
    exec(16'he955);
    `CHK(cfg_o.irq_enable, 7'h55);
    exec(16'hfb25);
    `CHK({cfg_o.buzz_src, cfg_o.buzz_mod}, 9'h125);
    exec(16'hfd9e);
    `CHK({cfg_o.el_pump_div_clk, cfg_o.el_pump_div, cfg_o.el_pump_duty}, 5'h19);
    `CHK({cfg_o.el_drive_clk, cfg_o.el_drive_duty}, 4'he);
    exec(16'hf09e);
    `CHK({flags_o.timer_reload_one, flags_o.watchdog_enable_flag}, 2'h3);
    `CHK({flags_o.halt_after_el, flags_o.el_light, flags_o.backup_flag}, 3'h7);
    exec(16'hf486);
    `CHK({flags_o.timer_reload_one, flags_o.el_light, flags_o.backup_flag}, 3'h0);
    `CHK({wd_o, flags_o.watchdog_enable_flag, flags_o.carry_flag}, 3'h3);
    exec(16'heb00);
    `CHK(pd_o, 1'b1);
    exec(16'hed20);
    `CHK(cfg_o.stop_wake_enable, 3'h2);
    exec(16'hff00);
    stop_evt_i = 3'h1;
    exec(16'h0000);
    `CHK(stopped_o, 1'b1);
    stop_evt_i = 3'h2;
    exec(16'h0000);
    stop_evt_i = 3'h0;
    `CHK(stopped_o, 1'b0);
    exec(16'he802);
    exec(16'hfe00);
    p = pc_o;
    `CHK(halted_o, 1'b1);
    wake_evt_i = 7'h04;
    exec(16'hd300);
    wake_evt_i = 7'h00;
    repeat (2) @(posedge mclk_i);
    #1;
    `CHK({halted_o, pc_o}, {1'b1, p});
    wake_evt_i = 7'h02;
    @(posedge mclk_i);
    #1;
    wake_evt_i = 7'h00;
    for (int k = 0; k < 4 && halted_o !== 1'b0; k++) begin
      @(posedge mclk_i);
      #1;
    end
    `CHK(halted_o, 1'b0);
    if (halted_o !== 1'b0) tally_and_finish();
    `CHK(halt_wake_request_o[1], 1'b1);
    exec(16'hea02);
    `CHK(halt_wake_request_o[1], 1'b0);
    sys_rst_i = 1;
    #1;
    `CHK({pc_o, acc_o, flags_o, cfg_o, halt_wake_request_o}, '0);
    @(posedge mclk_i);
    #1;
    sys_rst_i = 0;
    exec(16'h0000);
    `CHK(pc_o, 11'h001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
